// >>> core/spc_ctrl.sv
// spc_ctrl: serial port control/status registers, address detect, error flags, baud timer
// assumes: receiver datapath delivers finished characters as one-cycle pulses on RX_DONE_*
//
// Summary of operation
// - with 9-bit async and address detect, load buffer only when ninth bit is one.
// - address detect off in 9-bit async: accept every character.
// - address detect has no effect when 8-bit reception is selected.
// - in 9-bit async address-detect mode every buffered character reads ninth bit one.
// - overrun stays set until continuous receive cleared; clearing it clears overrun.
// - framing error follows top character, advancing when receive data is read.
// - port enable zero holds port in reset; one assigns pins to port.
// - single receive starts one master sync reception, self-clears; ignored otherwise.
// - continuous receive enables async receiver; sync: runs until cleared, beats single.
// - in sync mode receive enables take precedence over transmit enable.
// - sync clock source: one master from baud timer, zero slave external.
// - transmit 9-bit select picks nine or eight bit characters using tx ninth bit.
// - shift register empty reads one when empty, zero when full; resets one.
// - mode select one synchronous, zero asynchronous.
// - baud timer is dedicated 8-bit free-running timer set by divisor.
// - high speed select changes multiplier in async only.
// - writing baud divisor clears the baud timer immediately.
// - receive 9-bit select makes receiver shift nine bits, else eight.
// - received ninth bit readable; parity check left to firmware.
// - baud = clock / (64, 16 or 4 times divisor plus one).
// - buffer holds two characters; overrun when third completes unread.
`timescale 1ns/1ps
`default_nettype none
module spc_ctrl
  import spc_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RESETN,
  input  wire logic [spc_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output var  logic [7:0]        RDATA,
  input  wire logic              RX_DONE,
  input  wire logic [7:0]        RX_DONE_DATA,
  input  wire logic              RX_DONE_NINTH,
  input  wire logic              RX_DONE_FRAME_ERR,
  input  wire logic              TX_SHIFT_BUSY,
  output var  logic              BAUD_TICK,
  output var  logic              PORT_ACTIVE,
  output var  logic              SYNC_MODE,
  output var  logic              SYNC_MASTER,
  output var  logic              RX_ENABLE,
  output var  logic              RX_NINE_BITS,
  output var  logic              TX_ENABLE,
  output var  logic              TX_NINE_BITS,
  output var  logic              TX_NINTH,
  output var  logic              RX_INT_FLAG
);
  import spc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  logic       port_enable_reg;
  logic       rx_nine_bit_select_reg;
  logic       single_receive_enable_reg;
  logic       continuous_receive_enable_reg;
  logic       address_detect_enable_reg;
  logic       overrun_error_flag_reg;
  logic       clock_source_select_reg;
  logic       tx_nine_bit_select_reg;
  logic       transmit_enable_reg;
  logic       sync_mode_reg;
  logic       high_speed_select_reg;
  logic       tx_ninth_bit_reg;
  logic [7:0] baud_divisor_reg;
  logic       shift_reg_empty_reg;
  logic       busy_s1_reg;
  logic       busy_s2_reg;

  logic       wr_rx_stat;
  logic       wr_tx_stat;
  logic       wr_baud;
  logic       rd_rx_data;
  logic       single_done;
  logic       sync_master;
  logic       port_off;

  assign wr_rx_stat  = WR && ADDR == ADDR_RX_STAT;
  assign wr_tx_stat  = WR && ADDR == ADDR_TX_STAT;
  assign wr_baud     = WR && ADDR == ADDR_BAUD_DIV;
  assign rd_rx_data  = RD && ADDR == ADDR_RX_DATA;
  assign port_off    = !RESETN || !port_enable_reg;
  assign sync_master = sync_mode_reg && clock_source_select_reg;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      port_enable_reg               <= 1'b0;
      rx_nine_bit_select_reg        <= 1'b0;
      continuous_receive_enable_reg <= 1'b0;
      address_detect_enable_reg     <= 1'b0;
    end else if (wr_rx_stat) begin
      port_enable_reg               <= WDATA[RS_PORT_EN];
      rx_nine_bit_select_reg        <= WDATA[RS_RX9_SEL];
      continuous_receive_enable_reg <= WDATA[RS_CONT_RX];
      address_detect_enable_reg     <= WDATA[RS_ADDR_DET];
    end
  end

  // single receive clears itself once the master reception completes
  assign single_done = sync_master && !continuous_receive_enable_reg && RX_DONE;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      single_receive_enable_reg <= 1'b0;
    end else if (wr_rx_stat) begin
      single_receive_enable_reg <= WDATA[RS_SINGLE_RX];
    end else if (single_done) begin
      single_receive_enable_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      clock_source_select_reg <= TX_STAT_RESET[TS_CLK_SRC];
      tx_nine_bit_select_reg  <= TX_STAT_RESET[TS_TX9_SEL];
      transmit_enable_reg     <= TX_STAT_RESET[TS_TX_EN];
      sync_mode_reg           <= TX_STAT_RESET[TS_SYNC];
      high_speed_select_reg   <= TX_STAT_RESET[TS_HIGH_SPD];
      tx_ninth_bit_reg        <= TX_STAT_RESET[TS_TX_NINTH];
    end else if (wr_tx_stat) begin
      clock_source_select_reg <= WDATA[TS_CLK_SRC];
      tx_nine_bit_select_reg  <= WDATA[TS_TX9_SEL];
      transmit_enable_reg     <= WDATA[TS_TX_EN];
      sync_mode_reg           <= WDATA[TS_SYNC];
      high_speed_select_reg   <= WDATA[TS_HIGH_SPD];
      tx_ninth_bit_reg        <= WDATA[TS_TX_NINTH];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      baud_divisor_reg <= BAUD_DIV_RESET;
    end else if (wr_baud) begin
      baud_divisor_reg <= WDATA;
    end
  end

  // busy comes from the shifter; synchronised in case it lives elsewhere
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      busy_s1_reg         <= 1'b0;
      busy_s2_reg         <= 1'b0;
      shift_reg_empty_reg <= 1'b1;
    end else begin
      busy_s1_reg         <= TX_SHIFT_BUSY;
      busy_s2_reg         <= busy_s1_reg;
      shift_reg_empty_reg <= port_off || !busy_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive acceptance, buffer and error flags

  logic       rx_on;
  logic       addr_filter;
  logic       accept;
  logic       push;
  logic [9:0] top_data;
  logic [1:0] fifo_count;

  // sync: continuous wins over single, single only counts as master
  assign rx_on = port_enable_reg && (sync_mode_reg
               ? (continuous_receive_enable_reg ||
                  (single_receive_enable_reg && clock_source_select_reg))
               : continuous_receive_enable_reg);
  // filter only in async 9-bit; in 8-bit the enable is ignored
  assign addr_filter = !sync_mode_reg && rx_nine_bit_select_reg
                       && address_detect_enable_reg;
  assign accept = rx_on && RX_DONE && (!addr_filter || RX_DONE_NINTH);
  // a full buffer blocks characters until read; a set overrun blocks all until it is cleared
  assign push   = accept && !overrun_error_flag_reg && (fifo_count != 2'(FIFO_DEPTH) || rd_rx_data);

  always_ff @(posedge REF_CLK) begin
    if (port_off || !continuous_receive_enable_reg) begin
      overrun_error_flag_reg <= 1'b0;
    end else if (accept && fifo_count == 2'(FIFO_DEPTH) && !rd_rx_data) begin
      overrun_error_flag_reg <= 1'b1;
    end
  end

  spc_rx_fifo #(
    .W (10)
  ) u_fifo (
    .clk       (REF_CLK),
    .clr       (port_off),
    .push      (push),
    // ninth bit only meaningful when nine bits are received
    .push_data ({RX_DONE_FRAME_ERR, RX_DONE_NINTH && rx_nine_bit_select_reg,
                 RX_DONE_DATA}),
    .pop       (rd_rx_data),
    .top_data  (top_data),
    .count     (fifo_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // baud timer: 8-bit divisor counter after a mode-selected prescaler

  logic [7:0] baud_cnt_reg;
  logic [5:0] pre_cnt_reg;
  logic [5:0] mult;
  logic       pre_wrap;

  // high speed only matters in async
  assign mult = sync_mode_reg ? MULT_SYNC
              : (high_speed_select_reg ? MULT_ASYNC_HIGH : MULT_ASYNC_LOW);
  assign pre_wrap = pre_cnt_reg >= mult;

  always_ff @(posedge REF_CLK) begin
    if (port_off || wr_baud) begin
      pre_cnt_reg  <= 6'h00;
      baud_cnt_reg <= 8'h00;
    end else if (pre_wrap) begin
      pre_cnt_reg  <= 6'h00;
      baud_cnt_reg <= (baud_cnt_reg >= baud_divisor_reg) ? 8'h00
                      : baud_cnt_reg + 8'h01;
    end else begin
      pre_cnt_reg  <= pre_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (port_off || wr_baud) begin
      BAUD_TICK <= 1'b0;
    end else begin
      BAUD_TICK <= pre_wrap && baud_cnt_reg >= baud_divisor_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status outputs to the datapath

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      PORT_ACTIVE  <= 1'b0;
      SYNC_MODE    <= 1'b0;
      SYNC_MASTER  <= 1'b0;
      RX_ENABLE    <= 1'b0;
      RX_NINE_BITS <= 1'b0;
      TX_ENABLE    <= 1'b0;
      TX_NINE_BITS <= 1'b0;
      TX_NINTH     <= 1'b0;
      RX_INT_FLAG  <= 1'b0;
    end else begin
      PORT_ACTIVE  <= port_enable_reg;
      SYNC_MODE    <= sync_mode_reg;
      SYNC_MASTER  <= sync_master;
      RX_ENABLE    <= rx_on;
      RX_NINE_BITS <= rx_nine_bit_select_reg;
      TX_ENABLE    <= port_enable_reg && transmit_enable_reg &&
                      !(sync_mode_reg && rx_on);
      TX_NINE_BITS <= tx_nine_bit_select_reg;
      TX_NINTH     <= tx_ninth_bit_reg;
      // flag for the external interrupt controller
      RX_INT_FLAG  <= port_enable_reg && rx_on && (fifo_count != 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        ADDR_RX_DATA:  RDATA <= (fifo_count != 2'h0) ? top_data[7:0] : RX_DATA_RESET;
        ADDR_RX_STAT:  RDATA <= {port_enable_reg, rx_nine_bit_select_reg,
                                 single_receive_enable_reg, continuous_receive_enable_reg,
                                 address_detect_enable_reg,
                                 (fifo_count != 2'h0) && top_data[9],
                                 overrun_error_flag_reg,
                                 (fifo_count != 2'h0) && top_data[8]};
        ADDR_BAUD_DIV: RDATA <= baud_divisor_reg;
        ADDR_TX_STAT:  RDATA <= {clock_source_select_reg, tx_nine_bit_select_reg,
                                 transmit_enable_reg, sync_mode_reg, 1'b0,
                                 high_speed_select_reg, shift_reg_empty_reg,
                                 tx_ninth_bit_reg} & (TX_STAT_WMASK | 8'h02);
        default:       RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// >>> pkg/spc_pkg.sv
// spc_pkg: register map, field positions, reset values and baud multipliers
// assumes: plain register port, 8-bit data, index addressing
package spc_pkg;
  localparam int         ADDR_W         = 2;
  localparam logic [1:0] ADDR_RX_DATA   = 2'h0;
  localparam logic [1:0] ADDR_RX_STAT   = 2'h1;
  localparam logic [1:0] ADDR_BAUD_DIV  = 2'h2;
  localparam logic [1:0] ADDR_TX_STAT   = 2'h3;
  // receive_status_control fields
  localparam int RS_PORT_EN   = 7;
  localparam int RS_RX9_SEL   = 6;
  localparam int RS_SINGLE_RX = 5;
  localparam int RS_CONT_RX   = 4;
  localparam int RS_ADDR_DET  = 3;
  localparam int RS_FRAME_ERR = 2;
  localparam int RS_OVERRUN   = 1;
  localparam int RS_RX_NINTH  = 0;
  // transmit_status_control fields
  localparam int TS_CLK_SRC   = 7;
  localparam int TS_TX9_SEL   = 6;
  localparam int TS_TX_EN     = 5;
  localparam int TS_SYNC      = 4;
  localparam int TS_HIGH_SPD  = 2;
  localparam int TS_SR_EMPTY  = 1;
  localparam int TS_TX_NINTH  = 0;
  localparam logic [7:0] RX_DATA_RESET  = 8'h00;
  localparam logic [7:0] BAUD_DIV_RESET = 8'h00;
  localparam logic [7:0] TX_STAT_RESET  = 8'h02;
  localparam logic [7:0] TX_STAT_WMASK  = 8'hf5;
  // baud period multipliers (prescale counts)
  localparam logic [5:0] MULT_ASYNC_LOW  = 6'h3f;
  localparam logic [5:0] MULT_ASYNC_HIGH = 6'h0f;
  localparam logic [5:0] MULT_SYNC       = 6'h03;
  localparam int         FIFO_DEPTH      = 2;
endpackage

// >>> core/spc_rx_fifo.sv
// spc_rx_fifo: two-entry receive buffer, 8 data bits plus ninth bit and framing error
// assumes: push and pop from the same clock; read data registered
`timescale 1ns/1ps
`default_nettype none
module spc_rx_fifo #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         clr,
  input  wire logic         push,
  input  wire logic [W-1:0] push_data,
  input  wire logic         pop,
  output var  logic [W-1:0] top_data,
  output var  logic [1:0]   count
);
  import spc_pkg::*;
  logic [W-1:0] second_reg;
  logic [1:0]   count_reg;
  logic [W-1:0] top_reg;
  logic         do_pop;
  logic         do_push;
  assign do_pop  = pop && (count_reg != 2'h0);
  assign do_push = push && (count_reg != 2'(FIFO_DEPTH) || do_pop);
  assign count   = count_reg;
  assign top_data = top_reg;

  always_ff @(posedge clk) begin
    if (clr) begin
      count_reg <= 2'h0;
    end else begin
      count_reg <= count_reg + 2'(do_push) - 2'(do_pop);
    end
  end

  // top entry always holds the oldest unread character
  always_ff @(posedge clk) begin
    if (clr) begin
      top_reg    <= '0;
      second_reg <= '0;
    end else if (do_pop) begin
      if (count_reg == 2'h2) begin
        top_reg <= second_reg;
        if (do_push) second_reg <= push_data;
      end else if (do_push) begin
        top_reg <= push_data;
      end
    end else if (do_push) begin
      if (count_reg == 2'h0) top_reg <= push_data;
      else second_reg <= push_data;
    end
  end
endmodule
`default_nettype wire

// >>> verification/spc_ctrl_assertions.sv
// spc_ctrl_assertions: port-level checks of the serial port control block
// assumes: bound to spc_ctrl, one clock, reset synchronous active low
`timescale 1ns/1ps
`default_nettype none
module spc_ctrl_checker (
  input wire logic                      REF_CLK,
  input wire logic                      RESETN,
  input wire logic [spc_pkg::ADDR_W-1:0] ADDR,
  input wire logic [7:0]                WDATA,
  input wire logic                      WR,
  input wire logic                      RD,
  input wire logic [7:0]                RDATA,
  input wire logic                      BAUD_TICK,
  input wire logic                      PORT_ACTIVE,
  input wire logic                      SYNC_MODE,
  input wire logic                      SYNC_MASTER,
  input wire logic                      RX_ENABLE,
  input wire logic                      TX_ENABLE,
  input wire logic                      TX_NINE_BITS,
  input wire logic                      RX_INT_FLAG
);
  import spc_pkg::*;
  logic [7:0] w1_reg;
  logic [7:0] w2_reg;
  // write data two cycles back, to match registered control outputs
  always_ff @(posedge REF_CLK) begin
    w1_reg <= WDATA;
    w2_reg <= w1_reg;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////////////
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  unimpl_zero_a: assert property (RD && ADDR == ADDR_TX_STAT |=> !RDATA[3])
    else $error("unused transmit status bit read as one");
  tick_pulse_a: assert property (BAUD_TICK |=> !BAUD_TICK [*3])
    else $error("baud tick closer than four cycles");
  tick_clear_a: assert property (WR && ADDR == ADDR_BAUD_DIV |-> ##2 !BAUD_TICK [*2])
    else $error("baud tick right after divisor write");
  port_off_a: assert property (!PORT_ACTIVE |-> !RX_ENABLE && !RX_INT_FLAG)
    else $error("receiver active with port disabled");
  int_gate_a: assert property (RX_INT_FLAG |-> PORT_ACTIVE && RX_ENABLE)
    else $error("receive flag with receiver off");
  sync_tx_a: assert property (SYNC_MODE && RX_ENABLE |-> !TX_ENABLE)
    else $error("transmit enabled over sync receive");
  master_sync_a: assert property (SYNC_MASTER |-> SYNC_MODE)
    else $error("master clock outside sync mode");
  mode_apply_a: assert property (WR && ADDR == ADDR_TX_STAT |-> ##2 (!PORT_ACTIVE ||
    (SYNC_MODE == w2_reg[TS_SYNC] && TX_NINE_BITS == w2_reg[TS_TX9_SEL])))
    else $error("mode outputs do not follow transmit status write");
endmodule
bind spc_ctrl spc_ctrl_checker u_spc_ctrl_checker (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .BAUD_TICK(BAUD_TICK), .PORT_ACTIVE(PORT_ACTIVE), .SYNC_MODE(SYNC_MODE),
  .SYNC_MASTER(SYNC_MASTER), .RX_ENABLE(RX_ENABLE), .TX_ENABLE(TX_ENABLE),
  .TX_NINE_BITS(TX_NINE_BITS), .RX_INT_FLAG(RX_INT_FLAG)
);
`default_nettype wire

// >>> verification/spc_remote_station.sv
// spc_remote_station: far station delivering finished characters and shifter state
// assumes: driven by the bench through its tasks, same clock as the block
`timescale 1ns/1ps
`default_nettype none
module spc_remote_station (
  input  wire logic       clk,
  output var  logic       done,
  output var  logic [7:0] data,
  output var  logic       ninth,
  output var  logic       frame_err,
  output var  logic       busy
);
  initial begin
    done = 1'b0;
    data = 8'h00;
    ninth = 1'b0;
    frame_err = 1'b0;
    busy = 1'b0;
  end
  // qualifiers flip after the pulse so nothing leans on a stale value
  task automatic send(input logic [7:0] d, input logic n, input logic f, input int gap);
    @(posedge clk);
    done <= 1'b1;
    data <= d;
    ninth <= n;
    frame_err <= f;
    @(posedge clk);
    done <= 1'b0;
    data <= ~d;
    ninth <= ~n;
    frame_err <= ~f;
    repeat (gap) @(posedge clk);
    #1;
  endtask
  task automatic set_busy(input logic b);
    @(posedge clk);
    busy <= b;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_spc_ctrl.sv
// tb_spc_ctrl: register-level tests of the serial port control block
// assumes: spc_ctrl, its checker and the remote station model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_spc_ctrl;
  import spc_pkg::*;
  logic                clk;
  logic                rst_n;
  logic                wr_s;
  logic                rd_s;
  logic [ADDR_W-1:0]   addr;
  logic [7:0]          wdata;
  logic [7:0]          rdata;
  logic [7:0]          rxd;
  logic                done, nin, fe, busy, tick, pa, sm, ms, re, r9, te, t9, tn, irq;
  logic [8:0]          st;
  int                  err_total;
  int                  tests_run;
  int                  p;
  int                  i;
  logic [7:0]          md [4] = '{8'h00, 8'h04, 8'h10, 8'h14};
  logic [8:0]          mul [4] = '{{3'h0, MULT_ASYNC_LOW} + 9'h1, {3'h0, MULT_ASYNC_HIGH} + 9'h1,
                                   {3'h0, MULT_SYNC} + 9'h1, {3'h0, MULT_SYNC} + 9'h1};
  assign st = {pa, sm, ms, re, r9, te, t9, tn, irq};
  spc_ctrl u_spc_ctrl (
    .REF_CLK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .RX_DONE(done), .RX_DONE_DATA(rxd), .RX_DONE_NINTH(nin),
    .RX_DONE_FRAME_ERR(fe), .TX_SHIFT_BUSY(busy), .BAUD_TICK(tick), .PORT_ACTIVE(pa),
    .SYNC_MODE(sm), .SYNC_MASTER(ms), .RX_ENABLE(re), .RX_NINE_BITS(r9), .TX_ENABLE(te),
    .TX_NINE_BITS(t9), .TX_NINTH(tn), .RX_INT_FLAG(irq)
  );
  spc_remote_station u_remote (
    .clk(clk), .done(done), .data(rxd), .ninth(nin), .frame_err(fe), .busy(busy)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [8:0] e);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk({1'b0, rdata}, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // cycles up to and including the next baud tick
  task automatic per(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 3000);
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize;
  end
  initial begin
    err_total = 0;
    tests_run = 0;
    rst_n = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_TX_STAT, 9'h002);
    rd(ADDR_RX_STAT, 9'h000);
    rd(ADDR_RX_DATA, 9'h000);
    wr(ADDR_TX_STAT, 8'hff);
    rd(ADDR_TX_STAT, 9'h0f7);
    // a disabled port holds the shifter status in reset, so enable it first
    wr(ADDR_RX_STAT, 8'h80);
    u_remote.set_busy(1'b1);
    cyc(4);
    rd(ADDR_TX_STAT, 9'h0f5);
    u_remote.set_busy(1'b0);
    // baud periods per mode, divisor 2
    wr(ADDR_RX_STAT, 8'h80);
    wr(ADDR_BAUD_DIV, 8'h02);
    rd(ADDR_BAUD_DIV, 9'h002);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_TX_STAT, md[i]);
      per(p);
      per(p);
      chk(p[8:0], mul[i] * 9'd3);
    end
    wr(ADDR_TX_STAT, 8'h00);
    per(p);
    cyc(10);
    wr(ADDR_BAUD_DIV, 8'h00);
    per(p);
    chk({8'h00, p > 60 && p < 70}, 9'h001);
    // 8-bit async, address detect set but ignored
    wr(ADDR_RX_STAT, 8'h98);
    u_remote.send(8'h5a, 1'b0, 1'b1, 3);
    chk(st, 9'h121);
    rd(ADDR_RX_STAT, 9'h09c);
    rd(ADDR_RX_DATA, 9'h05a);
    cyc(2);
    chk(st, 9'h120);
    // 9-bit address detect
    wr(ADDR_RX_STAT, 8'hd8);
    u_remote.send(8'h11, 1'b0, 1'b0, 3);
    u_remote.send(8'h22, 1'b1, 1'b0, 20);
    rd(ADDR_RX_STAT, 9'h0d9);
    rd(ADDR_RX_DATA, 9'h022);
    wr(ADDR_RX_STAT, 8'hd0);
    u_remote.send(8'h33, 1'b0, 1'b1, 3);
    rd(ADDR_RX_STAT, 9'h0d4);
    rd(ADDR_RX_DATA, 9'h033);
    // two-deep buffer, overrun and framing order
    wr(ADDR_RX_STAT, 8'h90);
    u_remote.send(8'ha1, 1'b0, 1'b1, 3);
    u_remote.send(8'hb2, 1'b0, 1'b0, 3);
    u_remote.send(8'hc3, 1'b0, 1'b0, 3);
    rd(ADDR_RX_STAT, 9'h096);
    rd(ADDR_RX_DATA, 9'h0a1);
    rd(ADDR_RX_STAT, 9'h092);
    rd(ADDR_RX_DATA, 9'h0b2);
    u_remote.send(8'hd4, 1'b0, 1'b0, 3);
    chk(st, 9'h120);
    rd(ADDR_RX_DATA, 9'h000);
    wr(ADDR_RX_STAT, 8'h80);
    rd(ADDR_RX_STAT, 9'h080);
    wr(ADDR_RX_STAT, 8'h90);
    u_remote.send(8'he5, 1'b0, 1'b0, 3);
    rd(ADDR_RX_DATA, 9'h0e5);
    // sync master single receive, then slave and async
    wr(ADDR_TX_STAT, 8'hb0);
    wr(ADDR_RX_STAT, 8'ha0);
    cyc(3);
    chk(st, 9'h1e0);
    u_remote.send(8'h3c, 1'b0, 1'b0, 3);
    rd(ADDR_RX_STAT, 9'h080);
    chk(st, 9'h1c8);
    rd(ADDR_RX_DATA, 9'h03c);
    wr(ADDR_TX_STAT, 8'h30);
    wr(ADDR_RX_STAT, 8'ha0);
    cyc(3);
    chk(st, 9'h188);
    wr(ADDR_RX_STAT, 8'h90);
    cyc(3);
    chk(st, 9'h1a0);
    wr(ADDR_TX_STAT, 8'he1);
    wr(ADDR_RX_STAT, 8'ha0);
    cyc(3);
    chk(st, 9'h10e);
    // port off drops everything, buffer included
    wr(ADDR_TX_STAT, 8'h00);
    wr(ADDR_RX_STAT, 8'h90);
    u_remote.send(8'h77, 1'b0, 1'b0, 3);
    wr(ADDR_RX_STAT, 8'h00);
    cyc(2);
    chk(st, 9'h000);
    wr(ADDR_RX_STAT, 8'h90);
    rd(ADDR_RX_DATA, 9'h000);
    summarize;
  end
endmodule
`default_nettype wire
